// file: verilog/card_irq_status.sv
// raw interrupt source, mask, clear and level registers of the card host
// Behaviour
// - response checksum failure sets bit 14
// - idle data machine with line three low sets bit 13
// - idle data machine with line three high sets bit 12
// - command fully sent sets bit 11
// - card leaving busy sets bit 10
// - card side transmit queue overrun or misalignment sets bit 9
// - card side receive queue underrun or misalignment sets bit 8
// - bus side receive queue underrun or misaligned read sets bit 7
// - bus side transmit queue overrun or misaligned write sets bit 6
// - word write with byte pointer off byte zero is misaligned
// - receive queue becoming full sets bit 5
// - receive byte count above receive level sets bit 4
// - receive queue leaving empty sets bit 3
// - transmit queue leaving full sets bit 2
// - transmit free space above transmit level sets bit 1
// - transmit queue becoming empty sets bit 0
// - source register at 0x00 shows flags unmasked
// - mask bit one blocks a source, zero passes; all reset to one
// - writing one at clear register 0x08 clears that flag
// - receive level lives in bits 15 to 8 of level register
`timescale 1ns/10ps
`default_nettype none
module card_irq_status #(
  parameter int COUNT_W = 9
) (
  // system clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // card clock domain
  input  wire logic               card_clk_i,
  input  wire logic               card_rst_i,
  input  wire logic               resp_crc_fail_i,
  input  wire logic               cmd_sent_i,
  input  wire logic               card_busy_i,
  input  wire logic               txq_pop_fault_i,
  input  wire logic               rxq_push_fault_i,
  input  wire logic               data_idle_i,
  // card pin
  input  wire logic               card_data_line3_i,
  // queue status, system clock
  input  wire logic               rxq_full_i,
  input  wire logic               rxq_empty_i,
  input  wire logic [COUNT_W-1:0] rxq_count_i,
  input  wire logic               txq_full_i,
  input  wire logic               txq_empty_i,
  input  wire logic [COUNT_W-1:0] txq_free_i,
  // bus side queue accesses, system clock
  input  wire logic               rxq_read_i,
  input  wire logic               rxq_read_word_i,
  input  wire logic [1:0]         rxq_byte_ptr_i,
  input  wire logic               rxq_underrun_i,
  input  wire logic               txq_write_i,
  input  wire logic               txq_write_word_i,
  input  wire logic [1:0]         txq_byte_ptr_i,
  input  wire logic               txq_overrun_i,
  // apb register port
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // interrupt
  output logic                    irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [18:0]                        flags;
    logic [18:0]                        mask;
    logic [7:0]                         rx_level;
    logic [7:0]                         tx_level;
    logic [31:0]                        rdata;
    logic                               irq;
    logic [sd_irq_pkg::CARD_EVENTS-1:0] toggle_seen;
    logic                               rx_empty_d;
    logic                               tx_full_d;
    logic                               rx_full_d;
    logic                               tx_empty_d;
  } irq_state_t;

  irq_state_t                         s;
  irq_state_t                         next_s;
  logic [sd_irq_pkg::CARD_EVENTS-1:0] toggle_sync_src;
  logic [sd_irq_pkg::CARD_EVENTS-1:0] toggle_sync;
  logic [sd_irq_pkg::CARD_EVENTS-1:0] card_event;
  logic [1:0]                         pin_sync;
  logic                               line3;
  logic                               idle;
  logic [18:0]                        set_flags;
  logic [18:0]                        clear_flags;
  logic                               bus_pop_err;
  logic                               bus_push_err;
  logic                               wr_access;
  logic                               rd_setup;

  // ==========================================================
  // decode
  function automatic logic hit(input logic [11:0] addr,
                               input logic [11:0] offset);
    hit = (addr == offset);
  endfunction

  // ==========================================================
  // card domain and crossings
  card_event_link card_link (
    .card_clk_i       (card_clk_i),
    .card_rst_i       (card_rst_i),
    .resp_crc_fail_i  (resp_crc_fail_i),
    .cmd_sent_i       (cmd_sent_i),
    .card_busy_i      (card_busy_i),
    .txq_pop_fault_i  (txq_pop_fault_i),
    .rxq_push_fault_i (rxq_push_fault_i),
    .event_toggle_o   (toggle_sync_src)
  );

  level_sync #(
    .WIDTH (sd_irq_pkg::CARD_EVENTS)
  ) toggle_cross (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (toggle_sync_src),
    .sync_o  (toggle_sync)
  );

  // pin and idle level both come from outside this clock
  level_sync #(
    .WIDTH (2)
  ) level_cross (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({data_idle_i, card_data_line3_i}),
    .sync_o  (pin_sync)
  );

  assign line3     = pin_sync[0];
  assign idle      = pin_sync[1];
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;

  // ==========================================================
  // event sources
  always_comb begin
    card_event = toggle_sync ^ s.toggle_seen;
    // misaligned: word access while byte pointer is off byte zero
    bus_pop_err  = rxq_read_i & (rxq_underrun_i | (rxq_read_word_i
                   & (rxq_byte_ptr_i != sd_irq_pkg::BYTE_ZERO)));
    bus_push_err = txq_write_i & (txq_overrun_i | (txq_write_word_i
                   & (txq_byte_ptr_i != sd_irq_pkg::BYTE_ZERO)));
    set_flags = sd_irq_pkg::FLAGS_RESET;
    set_flags[sd_irq_pkg::RESP_CRC_BIT] =
      card_event[sd_irq_pkg::EV_RESP_CRC];
    set_flags[sd_irq_pkg::LINE3_LOW_BIT] = idle & ~line3;
    set_flags[sd_irq_pkg::LINE3_HIGH_BIT] = idle & line3;
    set_flags[sd_irq_pkg::CMD_SENT_BIT] =
      card_event[sd_irq_pkg::EV_CMD_SENT];
    set_flags[sd_irq_pkg::BUSY_END_BIT] =
      card_event[sd_irq_pkg::EV_BUSY_END];
    set_flags[sd_irq_pkg::CARD_POP_BIT] =
      card_event[sd_irq_pkg::EV_CARD_POP];
    set_flags[sd_irq_pkg::CARD_PUSH_BIT] =
      card_event[sd_irq_pkg::EV_CARD_PUSH];
    set_flags[sd_irq_pkg::BUS_POP_BIT] = bus_pop_err;
    set_flags[sd_irq_pkg::BUS_PUSH_BIT] = bus_push_err;
    set_flags[sd_irq_pkg::RXQ_FULL_BIT] = rxq_full_i & ~s.rx_full_d;
    set_flags[sd_irq_pkg::RXQ_THRESH_BIT] =
      (rxq_count_i > COUNT_W'(s.rx_level));
    set_flags[sd_irq_pkg::RXQ_NEMPTY_BIT] =
      ~rxq_empty_i & s.rx_empty_d;
    set_flags[sd_irq_pkg::TXQ_NFULL_BIT] = ~txq_full_i & s.tx_full_d;
    set_flags[sd_irq_pkg::TXQ_THRESH_BIT] =
      (txq_free_i > COUNT_W'(s.tx_level));
    set_flags[sd_irq_pkg::TXQ_EMPTY_BIT] =
      txq_empty_i & ~s.tx_empty_d;
  end

  // ==========================================================
  // register file and flag update
  always_comb begin
    next_s = s;
    clear_flags = sd_irq_pkg::FLAGS_RESET;
    next_s.toggle_seen = toggle_sync;
    next_s.rx_empty_d  = rxq_empty_i;
    next_s.tx_full_d   = txq_full_i;
    next_s.rx_full_d   = rxq_full_i;
    next_s.tx_empty_d  = txq_empty_i;
    if (wr_access) begin
      if (hit(paddr_i, sd_irq_pkg::CLEAR_OFFSET)) begin
        clear_flags = pwdata_i[18:0];
      end
      if (hit(paddr_i, sd_irq_pkg::MASK_OFFSET)) begin
        next_s.mask = pwdata_i[18:0];
      end
      if (hit(paddr_i, sd_irq_pkg::LEVEL_OFFSET)) begin
        next_s.rx_level = pwdata_i[sd_irq_pkg::RX_LEVEL_LSB +: 8];
        next_s.tx_level = pwdata_i[sd_irq_pkg::TX_LEVEL_LSB +: 8];
      end
    end
    // a set in the same cycle as its clear wins
    next_s.flags = (s.flags & ~clear_flags) | set_flags;
    next_s.irq = |(next_s.flags & ~next_s.mask);
    // read data captured in the setup phase, stable in access
    if (rd_setup) begin
      case (paddr_i)
        sd_irq_pkg::SRC_OFFSET: begin
          next_s.rdata = {12'h000, line3, s.flags};
        end
        sd_irq_pkg::MASK_OFFSET: begin
          next_s.rdata = {13'h0000, s.mask};
        end
        sd_irq_pkg::LEVEL_OFFSET: begin
          next_s.rdata = {16'h0000, s.rx_level, s.tx_level};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s.flags       <= sd_irq_pkg::FLAGS_RESET;
      s.mask        <= sd_irq_pkg::MASK_RESET;
      s.rx_level    <= sd_irq_pkg::LEVEL_RESET;
      s.tx_level    <= sd_irq_pkg::LEVEL_RESET;
      s.rdata       <= 32'h0000_0000;
      s.irq         <= 1'b0;
      s.toggle_seen <= '0;
      s.rx_empty_d  <= 1'b1;
      s.tx_full_d   <= 1'b0;
      s.rx_full_d   <= 1'b0;
      s.tx_empty_d  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o  = s.rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign irq_o     = s.irq;

  // ==========================================================
  // checks
  property p_resp_crc;
    @(posedge clock_i) disable iff (rst_i)
    card_event[sd_irq_pkg::EV_RESP_CRC] |=>
      s.flags[sd_irq_pkg::RESP_CRC_BIT];
  endproperty
  a_resp_crc: assert property (p_resp_crc)
    else $error("response crc flag not set");

  property p_line3_low;
    @(posedge clock_i) disable iff (rst_i)
    (idle && !line3) |=> s.flags[sd_irq_pkg::LINE3_LOW_BIT];
  endproperty
  a_line3_low: assert property (p_line3_low)
    else $error("line three low flag not set");

  property p_line3_high;
    @(posedge clock_i) disable iff (rst_i)
    (idle && line3) |=> s.flags[sd_irq_pkg::LINE3_HIGH_BIT];
  endproperty
  a_line3_high: assert property (p_line3_high)
    else $error("line three high flag not set");

  property p_cmd_sent;
    @(posedge clock_i) disable iff (rst_i)
    card_event[sd_irq_pkg::EV_CMD_SENT] |=>
      s.flags[sd_irq_pkg::CMD_SENT_BIT];
  endproperty
  a_cmd_sent: assert property (p_cmd_sent)
    else $error("command sent flag not set");

  property p_push_misaligned;
    @(posedge clock_i) disable iff (rst_i)
    (txq_write_i && txq_write_word_i && (txq_byte_ptr_i != 2'h0))
      |=> s.flags[sd_irq_pkg::BUS_PUSH_BIT];
  endproperty
  a_push_misaligned: assert property (p_push_misaligned)
    else $error("misaligned word write not flagged");

  property p_rx_not_empty;
    @(posedge clock_i) disable iff (rst_i)
    $fell(rxq_empty_i) |=> s.flags[sd_irq_pkg::RXQ_NEMPTY_BIT];
  endproperty
  a_rx_not_empty: assert property (p_rx_not_empty)
    else $error("receive not empty flag not set");

  property p_rx_thresh;
    @(posedge clock_i) disable iff (rst_i)
    (rxq_count_i > COUNT_W'(s.rx_level)) |=>
      s.flags[sd_irq_pkg::RXQ_THRESH_BIT];
  endproperty
  a_rx_thresh: assert property (p_rx_thresh)
    else $error("receive threshold flag not set");

  property p_clear_empty;
    @(posedge clock_i) disable iff (rst_i)
    (wr_access && (paddr_i == 12'h008) && pwdata_i[0]
      && !set_flags[0]) |=> !s.flags[sd_irq_pkg::TXQ_EMPTY_BIT];
  endproperty
  a_clear_empty: assert property (p_clear_empty)
    else $error("clear write did not clear flag");

  property p_irq_gate;
    @(posedge clock_i) disable iff (rst_i)
    irq_o == |(s.flags & ~s.mask);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt output disagrees with flags");

endmodule
`default_nettype wire

// file: verilog/sd_irq_pkg.sv
// constants shared by the card interrupt source logic
package sd_irq_pkg;

  // ==========================================================
  // register offsets
  localparam logic [11:0] SRC_OFFSET   = 12'h000;
  localparam logic [11:0] MASK_OFFSET  = 12'h004;
  localparam logic [11:0] CLEAR_OFFSET = 12'h008;
  localparam logic [11:0] LEVEL_OFFSET = 12'h038;

  // ==========================================================
  // flag layout
  localparam int FLAG_COUNT      = 19;
  localparam int RESP_CRC_BIT    = 14;
  localparam int LINE3_LOW_BIT   = 13;
  localparam int LINE3_HIGH_BIT  = 12;
  localparam int CMD_SENT_BIT    = 11;
  localparam int BUSY_END_BIT    = 10;
  localparam int CARD_POP_BIT    = 9;
  localparam int CARD_PUSH_BIT   = 8;
  localparam int BUS_POP_BIT     = 7;
  localparam int BUS_PUSH_BIT    = 6;
  localparam int RXQ_FULL_BIT    = 5;
  localparam int RXQ_THRESH_BIT  = 4;
  localparam int RXQ_NEMPTY_BIT  = 3;
  localparam int TXQ_NFULL_BIT   = 2;
  localparam int TXQ_THRESH_BIT  = 1;
  localparam int TXQ_EMPTY_BIT   = 0;
  localparam int LINE3_STATE_BIT = 19;

  // ==========================================================
  // level register layout
  localparam int LEVEL_W      = 8;
  localparam int RX_LEVEL_LSB = 8;
  localparam int TX_LEVEL_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [18:0] FLAGS_RESET = 19'h00000;
  localparam logic [18:0] MASK_RESET  = 19'h7FFFF;
  localparam logic [7:0]  LEVEL_RESET = 8'h00;
  localparam logic [1:0]  BYTE_ZERO   = 2'h0;

  // ==========================================================
  // card side events, one toggle each
  localparam int CARD_EVENTS  = 5;
  localparam int EV_RESP_CRC  = 0;
  localparam int EV_CMD_SENT  = 1;
  localparam int EV_BUSY_END  = 2;
  localparam int EV_CARD_POP  = 3;
  localparam int EV_CARD_PUSH = 4;

endpackage

// file: verilog/level_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s.first  = async_i;
    next_s.second = s.first;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.second;

endmodule
`default_nettype wire

// file: verilog/card_event_link.sv
// card clock side: turns card events into toggles for crossing
`timescale 1ns/10ps
`default_nettype none
module card_event_link (
  // card clock and reset
  input  wire logic                             card_clk_i,
  input  wire logic                             card_rst_i,
  // card side events
  input  wire logic                             resp_crc_fail_i,
  input  wire logic                             cmd_sent_i,
  input  wire logic                             card_busy_i,
  input  wire logic                             txq_pop_fault_i,
  input  wire logic                             rxq_push_fault_i,
  // toggles toward the system clock
  output logic [sd_irq_pkg::CARD_EVENTS-1:0]    event_toggle_o
);

  typedef struct packed {
    logic [sd_irq_pkg::CARD_EVENTS-1:0] toggle;
    logic                               busy_d;
  } card_state_t;

  card_state_t                        s;
  card_state_t                        next_s;
  logic [sd_irq_pkg::CARD_EVENTS-1:0] event_now;

  // a toggle survives a stopped card clock, a pulse would not
  always_comb begin
    event_now = '0;
    event_now[sd_irq_pkg::EV_RESP_CRC]  = resp_crc_fail_i;
    event_now[sd_irq_pkg::EV_CMD_SENT]  = cmd_sent_i;
    event_now[sd_irq_pkg::EV_BUSY_END]  = s.busy_d & ~card_busy_i;
    event_now[sd_irq_pkg::EV_CARD_POP]  = txq_pop_fault_i;
    event_now[sd_irq_pkg::EV_CARD_PUSH] = rxq_push_fault_i;
    next_s.toggle = s.toggle ^ event_now;
    next_s.busy_d = card_busy_i;
  end

  always_ff @(posedge card_clk_i) begin
    if (card_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign event_toggle_o = s.toggle;

  property p_busy_end_toggle;
    @(posedge card_clk_i) disable iff (card_rst_i)
    $fell(card_busy_i) |=> (event_toggle_o[sd_irq_pkg::EV_BUSY_END]
      != $past(event_toggle_o[sd_irq_pkg::EV_BUSY_END]));
  endproperty
  a_busy_end_toggle: assert property (p_busy_end_toggle)
    else $error("busy end did not toggle");

endmodule
`default_nettype wire

// file: verification/card_side_model.sv
// card side partner: event pulses and data line three, card clock domain
`timescale 1ns/10ps
`default_nettype none
module card_side_model (
  // card clock
  input  wire logic card_clk_i,
  // card events and pin
  output logic      resp_crc_fail_o,
  output logic      cmd_sent_o,
  output logic      card_busy_o,
  output logic      txq_pop_fault_o,
  output logic      rxq_push_fault_o,
  output logic      line3_o
);
  // ==========================================================
  // idle levels; line three rests high like a pulled-up pin
  initial begin
    {resp_crc_fail_o, cmd_sent_o, card_busy_o} = 3'h0;
    {txq_pop_fault_o, rxq_push_fault_o} = 2'h0;
    line3_o = 1'h1;
  end

  // ==========================================================
  // one event, changed only on falling card edges
  // busy is a level, so it stays up three cycles before ending
  task automatic fire(input int ev);
    @(negedge card_clk_i);
    case (ev)
      0: resp_crc_fail_o <= 1'h1;
      1: cmd_sent_o <= 1'h1;
      2: card_busy_o <= 1'h1;
      3: txq_pop_fault_o <= 1'h1;
      default: rxq_push_fault_o <= 1'h1;
    endcase
    repeat ((ev == 2) ? 3 : 1) @(negedge card_clk_i);
    {resp_crc_fail_o, cmd_sent_o, card_busy_o} <= 3'h0;
    {txq_pop_fault_o, rxq_push_fault_o} <= 2'h0;
  endtask

  // pin level, asynchronous to the system clock
  task automatic set_line3(input logic lvl);
    line3_o = lvl;
  endtask
endmodule
`default_nettype wire

// file: verification/sd_card_interrupt_status_tb.sv
// self-checking bench for the card interrupt source registers
`timescale 1ns/10ps
`default_nettype none
module sd_card_interrupt_status_tb;
  // ==========================================================
  // stimulus and observed signals
  logic        clock_i, rst_i, card_clk_i, card_rst_i, data_idle_i;
  logic        rxq_full_i, rxq_empty_i, txq_full_i, txq_empty_i;
  logic [8:0]  rxq_count_i, txq_free_i;
  logic        rxq_read_i, rxq_read_word_i, rxq_underrun_i;
  logic        txq_write_i, txq_write_word_i, txq_overrun_i;
  logic [1:0]  rxq_byte_ptr_i, txq_byte_ptr_i;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        crc_w, sent_w, busy_w, pop_w, push_w, line3_w;
  int          num_errors, checks_done;
  int          ev_bit [5] = '{sd_irq_pkg::RESP_CRC_BIT,
    sd_irq_pkg::CMD_SENT_BIT, sd_irq_pkg::BUSY_END_BIT,
    sd_irq_pkg::CARD_POP_BIT, sd_irq_pkg::CARD_PUSH_BIT};

  // ==========================================================
  // clocks; card clock offset so the phases never line up
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  // first card rising edge comes early so card reset lands in a short reset
  initial begin
    card_clk_i = 1'h0;
    #3;
    forever begin
      card_clk_i = ~card_clk_i;
      #80;
    end
  end

  card_side_model card (.card_clk_i(card_clk_i), .resp_crc_fail_o(crc_w),
    .cmd_sent_o(sent_w), .card_busy_o(busy_w), .txq_pop_fault_o(pop_w),
    .rxq_push_fault_o(push_w), .line3_o(line3_w));

  card_irq_status #(.COUNT_W(9)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .card_clk_i(card_clk_i), .card_rst_i(card_rst_i),
    .resp_crc_fail_i(crc_w), .cmd_sent_i(sent_w), .card_busy_i(busy_w),
    .txq_pop_fault_i(pop_w), .rxq_push_fault_i(push_w),
    .data_idle_i(data_idle_i), .card_data_line3_i(line3_w),
    .rxq_full_i(rxq_full_i), .rxq_empty_i(rxq_empty_i),
    .rxq_count_i(rxq_count_i), .txq_full_i(txq_full_i),
    .txq_empty_i(txq_empty_i), .txq_free_i(txq_free_i),
    .rxq_read_i(rxq_read_i), .rxq_read_word_i(rxq_read_word_i),
    .rxq_byte_ptr_i(rxq_byte_ptr_i), .rxq_underrun_i(rxq_underrun_i),
    .txq_write_i(txq_write_i), .txq_write_word_i(txq_write_word_i),
    .txq_byte_ptr_i(txq_byte_ptr_i), .txq_overrun_i(txq_overrun_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));

  // ==========================================================
  // comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // register access: setup, access, release after the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(negedge clock_i);
    psel_i = 1'h1;
    pwrite_i = wr;
    paddr_i = a;
    pwdata_i = d;
    @(negedge clock_i);
    penable_i = 1'h1;
    @(posedge clock_i);
    chk({30'h0, pslverr_o, pready_o}, 32'h1);
    @(negedge clock_i);
    rd = prdata_o;
    {psel_i, penable_i, pwrite_i} = 3'h0;
  endtask

  // source read with line three state masked off; b < 0 means none set
  task automatic flag_is(input int b, input logic ie);
    apb(1'h0, sd_irq_pkg::SRC_OFFSET, 32'h0);
    chk(rd & 32'h7FFFF, (b < 0) ? 32'h0 : (32'h1 << b));
    chk({31'h0, irq_o}, {31'h0, ie});
  endtask

  task automatic clr();
    apb(1'h1, sd_irq_pkg::CLEAR_OFFSET, 32'h7FFFF);
    flag_is(-1, 1'h0);
  endtask

  // one bus side queue access pulse, then the expected error flag
  task automatic bus_acc(input logic tx, input logic word,
                         input logic [1:0] ptr, input logic bad, input int b);
    @(negedge clock_i);
    {txq_write_i, txq_write_word_i, txq_overrun_i} = {tx, word, bad & tx};
    {rxq_read_i, rxq_read_word_i, rxq_underrun_i} = {!tx, word, bad & !tx};
    {txq_byte_ptr_i, rxq_byte_ptr_i} = {ptr, ptr};
    @(negedge clock_i);
    {txq_write_i, txq_write_word_i, txq_overrun_i} = 3'h0;
    {rxq_read_i, rxq_read_word_i, rxq_underrun_i} = 3'h0;
    flag_is(b, b >= 0);
    clr();
  endtask

  // hang guard, far beyond the few microseconds needed
  initial begin
    #500000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  // ==========================================================
  // test sequence
  initial begin
    {rst_i, card_rst_i, data_idle_i} = 3'h6;
    {rxq_full_i, rxq_empty_i, txq_full_i, txq_empty_i} = 4'h6;
    {rxq_count_i, txq_free_i} = 18'h0;
    {rxq_read_i, rxq_read_word_i, rxq_underrun_i} = 3'h0;
    {txq_write_i, txq_write_word_i, txq_overrun_i} = 3'h0;
    {rxq_byte_ptr_i, txq_byte_ptr_i, psel_i, penable_i, pwrite_i} = 7'h0;
    {paddr_i, pwdata_i} = 44'h0;
    num_errors = 0;
    checks_done = 0;
    // the first card edge falls inside this reset, so 4 cycles suffice
    repeat (4) @(negedge clock_i);
    {rst_i, card_rst_i} = 2'h0;
    flag_is(-1, 1'h0);
    apb(1'h0, sd_irq_pkg::MASK_OFFSET, 32'h0);
    chk(rd, 32'h7FFFF);
    apb(1'h1, sd_irq_pkg::SRC_OFFSET, 32'hFFFFFFFF);
    flag_is(-1, 1'h0);
    apb(1'h0, sd_irq_pkg::CLEAR_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h03C, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // queue edges, first one while still masked
    rxq_full_i = 1'h1;
    flag_is(sd_irq_pkg::RXQ_FULL_BIT, 1'h0);
    apb(1'h1, sd_irq_pkg::MASK_OFFSET, 32'h0);
    flag_is(sd_irq_pkg::RXQ_FULL_BIT, 1'h1);
    clr();
    {rxq_full_i, rxq_empty_i} = 2'h0;
    flag_is(sd_irq_pkg::RXQ_NEMPTY_BIT, 1'h1);
    clr();
    rxq_empty_i = 1'h1;
    flag_is(-1, 1'h0);
    txq_full_i = 1'h0;
    flag_is(sd_irq_pkg::TXQ_NFULL_BIT, 1'h1);
    clr();
    txq_empty_i = 1'h1;
    flag_is(sd_irq_pkg::TXQ_EMPTY_BIT, 1'h1);
    clr();
    $display("test queue edges done");
    // thresholds at and one above the programmed levels
    apb(1'h1, sd_irq_pkg::LEVEL_OFFSET, 32'h1020);
    apb(1'h0, sd_irq_pkg::LEVEL_OFFSET, 32'h0);
    chk(rd, 32'h1020);
    rxq_count_i = 9'h010;
    flag_is(-1, 1'h0);
    rxq_count_i = 9'h011;
    flag_is(sd_irq_pkg::RXQ_THRESH_BIT, 1'h1);
    rxq_count_i = 9'h000;
    clr();
    txq_free_i = 9'h020;
    flag_is(-1, 1'h0);
    txq_free_i = 9'h021;
    flag_is(sd_irq_pkg::TXQ_THRESH_BIT, 1'h1);
    txq_free_i = 9'h000;
    clr();
    $display("test thresholds done");
    // bus side queue errors and misalignment
    bus_acc(1'h1, 1'h1, 2'h0, 1'h0, -1);
    bus_acc(1'h1, 1'h1, 2'h1, 1'h0, sd_irq_pkg::BUS_PUSH_BIT);
    bus_acc(1'h1, 1'h0, 2'h1, 1'h0, -1);
    bus_acc(1'h1, 1'h0, 2'h0, 1'h1, sd_irq_pkg::BUS_PUSH_BIT);
    bus_acc(1'h0, 1'h1, 2'h2, 1'h0, sd_irq_pkg::BUS_POP_BIT);
    bus_acc(1'h0, 1'h0, 2'h0, 1'h1, sd_irq_pkg::BUS_POP_BIT);
    $display("test bus errors done");
    // card events crossing from the card clock
    for (int k = 0; k < 5; k++) begin
      card.fire(k);
      repeat (20) @(negedge clock_i);
      flag_is(ev_bit[k], 1'h1);
      clr();
    end
    $display("test card events done");
    // line three levels while the data machine idles
    card.set_line3(1'h0);
    repeat (5) @(negedge clock_i);
    data_idle_i = 1'h1;
    repeat (5) @(negedge clock_i);
    flag_is(sd_irq_pkg::LINE3_LOW_BIT, 1'h1);
    chk(rd >> 19, 32'h0);
    data_idle_i = 1'h0;
    repeat (5) @(negedge clock_i);
    clr();
    card.set_line3(1'h1);
    repeat (5) @(negedge clock_i);
    data_idle_i = 1'h1;
    repeat (5) @(negedge clock_i);
    flag_is(sd_irq_pkg::LINE3_HIGH_BIT, 1'h1);
    chk(rd >> 19, 32'h1);
    data_idle_i = 1'h0;
    repeat (5) @(negedge clock_i);
    clr();
    $display("test line three done");
    test_done();
  end
endmodule
`default_nettype wire
